// ### src/pdc_pkg.sv
// package with register map, fields, reset values and modes of the power block
package pdc_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [14:0] ANALOG_PWR_OFS = 15'h0008;
  localparam logic [14:0] OUTBUF_PWR_OFS = 15'h0009;
  localparam logic [14:0] PD_MASK_OFS = 15'h000D;
  localparam logic [14:0] SYNC_REF_OFS = 15'h000E;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] ANALOG_PWR_RST = 8'h02;
  localparam logic [7:0] OUTBUF_PWR_RST = 8'h0C;
  localparam logic [7:0] PD_MASK_RST = 8'h00;
  localparam logic [7:0] SYNC_REF_RST = 8'h00;
  // ----------------------------------------
  // analog power register fields
  // ----------------------------------------
  localparam int CLK_BUF_OFF_BIT = 5;
  localparam int REF_AMP_OFF_BIT = 4;
  localparam int CHAN_A_OFF_BIT = 2;
  localparam int GLOBAL_OFF_REQ_BIT = 0;
  // ----------------------------------------
  // output buffer power register fields
  // ----------------------------------------
  localparam int FRAME_CLK_OUT_OFF_BIT = 5;
  localparam int BIT_CLK_OUT_OFF_BIT = 4;
  localparam int LANE_A1_OFF_BIT = 3;
  localparam int LANE_A0_OFF_BIT = 2;
  localparam int LANE_B1_OFF_BIT = 1;
  localparam int LANE_B0_OFF_BIT = 0;
  // ----------------------------------------
  // global power-down mask fields
  // ----------------------------------------
  localparam int KEEP_CLK_BUF_BIT = 3;
  localparam int KEEP_REF_AMP_BIT = 2;
  localparam int BANDGAP_OFF_SEL_BIT = 1;
  // ----------------------------------------
  // sync / reference control fields
  // ----------------------------------------
  localparam int PIN_ROLE_BIT = 7;
  localparam int SOFT_SYNC_TRIG_BIT = 6;
  localparam int SOFT_SYNC_EN_BIT = 5;
  localparam int REF_CONTROL_SOURCE_BIT = 3;
  localparam int REF_SEL_HI_BIT = 2;
  localparam int REF_SEL_LO_BIT = 1;
  localparam int SINGLE_ENDED_CLK_ENABLE_BIT = 0;
  // ----------------------------------------
  // serial frame layout: rw bit, 15 address bits, 8 data bits
  // ----------------------------------------
  localparam logic [4:0] FRAME_BITS = 5'h18;
  localparam logic [4:0] HDR_BITS = 5'h10;
  // ----------------------------------------
  // output interface modes
  // ----------------------------------------
  typedef enum logic [1:0] {
    PDC_TWO_WIRE,
    PDC_ONE_WIRE,
    PDC_HALF_WIRE
  } pdc_if_mode_t;
endpackage

// ### src/pdc_power_regs.sv
// power-down control register bank with its serial control port
`timescale 1ns/100ps
module pdc_power_regs (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // serial control port
  input wire logic i_sen_n,
  input wire logic i_sclk,
  input wire logic i_sdio,
  output logic o_sdout,
  output logic o_sdout_oe,
  // shared sync / power-down pin and output mode
  input wire logic i_shared_sync_powerdown_pin,
  input wire logic [1:0] i_if_mode,
  // analog block power-down controls
  output logic o_clk_buf_pd,
  output logic o_ref_amp_pd,
  output logic o_chan_a_pd,
  output logic o_bandgap_pd,
  output logic o_global_pd,
  // lvds output buffer power-down controls
  output logic o_frame_clk_out_pd,
  output logic o_bit_clk_out_pd,
  output logic o_lane_a1_pd,
  output logic o_lane_a0_pd,
  output logic o_lane_b1_pd,
  output logic o_lane_b0_pd,
  // sync and reference controls
  output logic o_sync,
  output logic o_ref_control_source,
  output logic [1:0] o_ref_sel,
  output logic o_single_ended_clk_enable
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] analog_r; // analog power control
  logic [7:0] outbuf_r; // output buffer power control
  logic [7:0] mask_r; // global power-down mask
  logic [7:0] syncref_r; // sync / reference control
  logic sclk_q_r; // previous serial clock level
  logic [4:0] cnt_r; // bits taken in this frame
  logic [22:0] sr_r; // incoming shift register
  logic [7:0] rd_r; // outgoing read shift register
  logic rd_act_r; // read data phase active
  logic trig_q_r; // previous soft sync trigger
  logic pin_q_r; // previous shared pin level
  logic sclk_rise; // serial clock rising edge
  logic sclk_fall; // serial clock falling edge
  logic [23:0] word; // full frame on last bit
  logic wr_stb; // write commit strobe
  logic glob; // global power-down in force
  logic narrow; // 1-wire or half-wire mode
  logic half; // half-wire mode

  // ----------------------------------------
  // read decode
  // ----------------------------------------
  // unmapped addresses read back as zero
  function automatic logic [7:0] rd_mux(input logic [14:0] a,
      input logic [7:0] r0, input logic [7:0] r1,
      input logic [7:0] r2, input logic [7:0] r3);
    logic [7:0] v;
    v = 8'h00;
    if (a == pdc_pkg::ANALOG_PWR_OFS) begin
      v = r0;
    end else if (a == pdc_pkg::OUTBUF_PWR_OFS) begin
      v = r1;
    end else if (a == pdc_pkg::PD_MASK_OFS) begin
      v = r2;
    end else if (a == pdc_pkg::SYNC_REF_OFS) begin
      v = r3;
    end
    return v;
  endfunction

  // ----------------------------------------
  // serial port edge detection and framing
  // ----------------------------------------
  // pins arrive synchronous, so edges come from one registered copy
  assign sclk_rise = i_sclk & ~sclk_q_r & ~i_sen_n;
  assign sclk_fall = ~i_sclk & sclk_q_r & ~i_sen_n;
  assign word = {sr_r, i_sdio};
  // a write lands on the last rising edge of a frame with rw low
  assign wr_stb = sclk_rise && (cnt_r == pdc_pkg::FRAME_BITS - 5'h01) &&
                  !sr_r[22];

  // serial clock history
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sclk_q_r <= 1'b0;
    end else begin
      sclk_q_r <= i_sclk;
    end
  end

  // bit counter and input shift; a deasserted enable aborts the frame
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_sen_n) begin
      cnt_r <= 5'h00;
      sr_r <= 23'h0;
    end else if (sclk_rise) begin
      // extra bits past a frame are ignored
      if (cnt_r != pdc_pkg::FRAME_BITS) begin
        cnt_r <= cnt_r + 5'h01;
      end
      sr_r <= word[22:0];
    end
  end

  // read data: loaded after the header, shifted on falling edges
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_sen_n) begin
      rd_r <= 8'h00;
      rd_act_r <= 1'b0;
    end else if (sclk_rise && (cnt_r == pdc_pkg::HDR_BITS - 5'h01) &&
                 sr_r[14]) begin
      // header bit 15 is rw; sr_r[14] holds it one edge before header end
      rd_r <= rd_mux({sr_r[13:0], i_sdio}, analog_r, outbuf_r, mask_r,
                     syncref_r);
      rd_act_r <= 1'b1;
    end else if (sclk_fall && rd_act_r && (cnt_r > pdc_pkg::HDR_BITS)) begin
      rd_r <= {rd_r[6:0], 1'b0};
      if (cnt_r == pdc_pkg::FRAME_BITS) begin
        rd_act_r <= 1'b0;
      end
    end
  end

  // serial data out pin, driven only during the read data phase
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_sdout <= 1'b0;
      o_sdout_oe <= 1'b0;
    end else begin
      o_sdout <= rd_r[7];
      o_sdout_oe <= rd_act_r;
    end
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  // every bit is stored as written; reserved bits are the host's concern
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      analog_r <= pdc_pkg::ANALOG_PWR_RST;
      outbuf_r <= pdc_pkg::OUTBUF_PWR_RST;
      mask_r <= pdc_pkg::PD_MASK_RST;
      syncref_r <= pdc_pkg::SYNC_REF_RST;
    end else if (wr_stb) begin
      if (word[22:8] == pdc_pkg::ANALOG_PWR_OFS) begin
        analog_r <= word[7:0];
      end else if (word[22:8] == pdc_pkg::OUTBUF_PWR_OFS) begin
        outbuf_r <= word[7:0];
      end else if (word[22:8] == pdc_pkg::PD_MASK_OFS) begin
        mask_r <= word[7:0];
      end else if (word[22:8] == pdc_pkg::SYNC_REF_OFS) begin
        syncref_r <= word[7:0];
      end
    end
  end

  // ----------------------------------------
  // power-down decisions
  // ----------------------------------------
  // pin in power-down role or register request starts global power-down
  assign glob = analog_r[pdc_pkg::GLOBAL_OFF_REQ_BIT] |
                (i_shared_sync_powerdown_pin & ~syncref_r[pdc_pkg::PIN_ROLE_BIT]);
  assign narrow = (i_if_mode == pdc_pkg::PDC_ONE_WIRE) ||
                  (i_if_mode == pdc_pkg::PDC_HALF_WIRE);
  assign half = (i_if_mode == pdc_pkg::PDC_HALF_WIRE);

  // analog block controls; individual bit or global both win, global masked for clock buffer, reference amp and bandgap
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_clk_buf_pd <= 1'b0;
      o_ref_amp_pd <= 1'b0;
      o_chan_a_pd <= 1'b0;
      o_bandgap_pd <= 1'b0;
      o_global_pd <= 1'b0;
    end else begin
      o_clk_buf_pd <= analog_r[pdc_pkg::CLK_BUF_OFF_BIT] |
          (glob & ~mask_r[pdc_pkg::KEEP_CLK_BUF_BIT]);
      o_ref_amp_pd <= analog_r[pdc_pkg::REF_AMP_OFF_BIT] |
          (glob & ~mask_r[pdc_pkg::KEEP_REF_AMP_BIT]);
      o_chan_a_pd <= analog_r[pdc_pkg::CHAN_A_OFF_BIT] | glob;
      // inverted sense: a set bit lets the bandgap go down too
      o_bandgap_pd <= glob & mask_r[pdc_pkg::BANDGAP_OFF_SEL_BIT];
      o_global_pd <= glob;
    end
  end

  // lvds buffer controls; global power-down silences the whole link
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_frame_clk_out_pd <= 1'b0;
      o_bit_clk_out_pd <= 1'b0;
      o_lane_a1_pd <= 1'b1;
      o_lane_a0_pd <= 1'b1;
      o_lane_b1_pd <= 1'b0;
      o_lane_b0_pd <= 1'b0;
    end else begin
      o_frame_clk_out_pd <= outbuf_r[pdc_pkg::FRAME_CLK_OUT_OFF_BIT] |
                            glob;
      o_bit_clk_out_pd <= outbuf_r[pdc_pkg::BIT_CLK_OUT_OFF_BIT] |
                          glob;
      o_lane_a1_pd <= outbuf_r[pdc_pkg::LANE_A1_OFF_BIT] | narrow |
                      glob;
      o_lane_a0_pd <= outbuf_r[pdc_pkg::LANE_A0_OFF_BIT] | glob;
      o_lane_b1_pd <= outbuf_r[pdc_pkg::LANE_B1_OFF_BIT] | narrow |
                      glob;
      o_lane_b0_pd <= outbuf_r[pdc_pkg::LANE_B0_OFF_BIT] | half |
                      glob;
    end
  end

  // ----------------------------------------
  // sync and reference controls
  // ----------------------------------------
  // trigger does not self-clear, so any toggle with the enable set syncs
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      trig_q_r <= 1'b0;
      pin_q_r <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      trig_q_r <= syncref_r[pdc_pkg::SOFT_SYNC_TRIG_BIT];
      pin_q_r <= i_shared_sync_powerdown_pin;
      o_sync <= (syncref_r[pdc_pkg::SOFT_SYNC_EN_BIT] &
                 (syncref_r[pdc_pkg::SOFT_SYNC_TRIG_BIT] ^ trig_q_r)) |
                (syncref_r[pdc_pkg::PIN_ROLE_BIT] & i_shared_sync_powerdown_pin &
                 ~pin_q_r);
    end
  end

  // reference fields take effect only under register control
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_ref_control_source <= 1'b0;
      o_ref_sel <= 2'h0;
      o_single_ended_clk_enable <= 1'b0;
    end else begin
      o_ref_control_source <= syncref_r[pdc_pkg::REF_CONTROL_SOURCE_BIT];
      o_ref_sel <= syncref_r[pdc_pkg::REF_CONTROL_SOURCE_BIT] ?
          syncref_r[pdc_pkg::REF_SEL_HI_BIT:pdc_pkg::REF_SEL_LO_BIT] :
          2'h0;
      o_single_ended_clk_enable <=
          syncref_r[pdc_pkg::REF_CONTROL_SOURCE_BIT] &
          syncref_r[pdc_pkg::SINGLE_ENDED_CLK_ENABLE_BIT];
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  clk_buf_pd_a:
  assert property (@(posedge i_clk) disable iff (i_sys_rst)
    analog_r[pdc_pkg::CLK_BUF_OFF_BIT] |=> o_clk_buf_pd)
    else $error("clock buffer not powered down");
  ref_amp_pd_a:
  assert property (@(posedge i_clk) disable iff (i_sys_rst)
    analog_r[pdc_pkg::REF_AMP_OFF_BIT] |=> o_ref_amp_pd)
    else $error("reference amplifier not powered down");
  chan_a_pd_a:
  assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!analog_r[pdc_pkg::CHAN_A_OFF_BIT] && !glob) |=> !o_chan_a_pd)
    else $error("channel A off without cause");
  global_req_a:
  assert property (@(posedge i_clk) disable iff (i_sys_rst)
    analog_r[pdc_pkg::GLOBAL_OFF_REQ_BIT] |=> (o_global_pd && o_chan_a_pd))
    else $error("global request not applied");
  frame_clk_pd_a:
  assert property (@(posedge i_clk) disable iff (i_sys_rst)
    outbuf_r[pdc_pkg::FRAME_CLK_OUT_OFF_BIT] |=> o_frame_clk_out_pd)
    else $error("frame clock buffer not off");
  lane_forced_a:
  assert property (@(posedge i_clk) disable iff (i_sys_rst)
    narrow |=> (o_lane_a1_pd && o_lane_b1_pd))
    else $error("lane 1 buffers not forced off");
  lane_b0_half_a:
  assert property (@(posedge i_clk) disable iff (i_sys_rst)
    half |=> o_lane_b0_pd)
    else $error("lane B0 not forced off in half-wire");
  keep_clk_buf_a:
  assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (glob && mask_r[pdc_pkg::KEEP_CLK_BUF_BIT] &&
     !analog_r[pdc_pkg::CLK_BUF_OFF_BIT]) |=> !o_clk_buf_pd)
    else $error("masked clock buffer went down");
  bandgap_sel_a:
  assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ##1 o_bandgap_pd == $past(glob && mask_r[pdc_pkg::BANDGAP_OFF_SEL_BIT]))
    else $error("bandgap state wrong");
  pin_sync_a:
  assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (syncref_r[pdc_pkg::PIN_ROLE_BIT] && $rose(i_shared_sync_powerdown_pin)) |=> o_sync)
    else $error("pin sync not issued");
  soft_sync_a:
  assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!syncref_r[pdc_pkg::SOFT_SYNC_EN_BIT] &&
     !syncref_r[pdc_pkg::PIN_ROLE_BIT]) |=> !o_sync)
    else $error("sync issued while disabled");
  bit_clk_pd_a:
  assert property (@(posedge i_clk) disable iff (i_sys_rst)
    outbuf_r[pdc_pkg::BIT_CLK_OUT_OFF_BIT] |=> o_bit_clk_out_pd)
    else $error("bit clock buffer not off");
  lane_a1_pd_a:
  assert property (@(posedge i_clk) disable iff (i_sys_rst)
    outbuf_r[pdc_pkg::LANE_A1_OFF_BIT] |=> o_lane_a1_pd)
    else $error("lane A1 buffer not off");
  lane_a0_on_a:
  assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!outbuf_r[pdc_pkg::LANE_A0_OFF_BIT] && !glob) |=> !o_lane_a0_pd)
    else $error("lane A0 buffer off without cause");
  keep_ref_amp_a:
  assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (glob && mask_r[pdc_pkg::KEEP_REF_AMP_BIT] &&
     !analog_r[pdc_pkg::REF_AMP_OFF_BIT]) |=> !o_ref_amp_pd)
    else $error("masked reference amplifier went down");
  ref_sel_field_a:
  assert property (@(posedge i_clk) disable iff (i_sys_rst)
    syncref_r[pdc_pkg::REF_CONTROL_SOURCE_BIT] |=>
    (o_ref_sel ==
     $past(syncref_r[pdc_pkg::REF_SEL_HI_BIT:pdc_pkg::REF_SEL_LO_BIT])))
    else $error("reference select not passed on");
  either_off_a:
  assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (analog_r[pdc_pkg::CHAN_A_OFF_BIT] || glob) |=> o_chan_a_pd)
    else $error("channel A kept on despite a request");

endmodule // pdc_power_regs

// ### tb/pdc_host_model.sv
// host model that drives the serial control port of the power block
`timescale 1ns/100ps
module pdc_host_model (
  // clock
  input wire logic i_clk,
  // serial control port, seen from the host
  input wire logic i_sdout,
  input wire logic i_sdout_oe,
  output logic o_sen_n,
  output logic o_sclk,
  output logic o_sdio
);
  // ----------------------------------------
  // idle state: deselected, clock low
  // ----------------------------------------
  initial begin
    o_sen_n = 1'b1;
    o_sclk = 1'b0;
    o_sdio = 1'b0;
  end
  // one 24-bit frame; each sclk level lasts two system clocks,
  // since the port samples sclk with the system clock
  task automatic xfer(input logic rd, input logic [14:0] adr,
                      input logic [7:0] wd, output logic [7:0] rdat,
                      output logic [7:0] oes);
    logic [23:0] fr;
    fr = {rd, adr, wd};
    rdat = 8'h00;
    oes = 8'h00;
    @(posedge i_clk) o_sen_n <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      @(posedge i_clk) o_sdio <= fr[i];
      @(posedge i_clk) o_sclk <= 1'b1;
      // the port takes the rise one clock later; by then the bit shifted
      // out on the last falling edge has reached the pin
      @(posedge i_clk) begin
        if (i < 8) begin
          rdat[i] = i_sdout;
          oes[i] = i_sdout_oe;
        end
      end
      @(posedge i_clk) o_sclk <= 1'b0;
    end
    @(posedge i_clk);
    // released data line shows the inverse, not a stale copy
    @(posedge i_clk) begin
      o_sen_n <= 1'b1;
      o_sdio <= ~o_sdio;
    end
  endtask
endmodule // pdc_host_model

// ### tb/power_down_control_regs_bench.sv
// self-checking bench for the power-down control registers
`timescale 1ns/100ps
module power_down_control_regs_bench;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_shared_sync_powerdown_pin = 1'b0;
  logic [1:0] i_if_mode = 2'h0;
  wire sen_n, sclk, sdio, sdout, sdout_oe, sync_p;
  wire [4:0] ana; // clk buf, ref amp, chan a, bandgap, global
  wire [5:0] lane; // frame, bit clock, a1, a0, b1, b0
  wire [3:0] refc; // source, select, single-ended enable
  logic [7:0] rdv;
  int n_errors = 0;
  int n_compared = 0;
  int n_sync = 0;
  int s;
  always #2.5 i_clk = ~i_clk;
  pdc_host_model u_host (.i_clk(i_clk), .i_sdout(sdout),
    .i_sdout_oe(sdout_oe), .o_sen_n(sen_n), .o_sclk(sclk),
    .o_sdio(sdio));
  pdc_power_regs u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_sen_n(sen_n), .i_sclk(sclk), .i_sdio(sdio), .o_sdout(sdout),
    .o_sdout_oe(sdout_oe), .i_shared_sync_powerdown_pin(i_shared_sync_powerdown_pin),
    .i_if_mode(i_if_mode), .o_clk_buf_pd(ana[4]),
    .o_ref_amp_pd(ana[3]), .o_chan_a_pd(ana[2]),
    .o_bandgap_pd(ana[1]), .o_global_pd(ana[0]),
    .o_frame_clk_out_pd(lane[5]), .o_bit_clk_out_pd(lane[4]),
    .o_lane_a1_pd(lane[3]), .o_lane_a0_pd(lane[2]),
    .o_lane_b1_pd(lane[1]), .o_lane_b0_pd(lane[0]),
    .o_sync(sync_p), .o_ref_control_source(refc[3]),
    .o_ref_sel(refc[2:1]), .o_single_ended_clk_enable(refc[0]));
  // count sync pulses; a pulse stands for one cycle only
  always @(posedge i_clk) begin
    if (sync_p === 1'b1) begin
      n_sync++;
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen,
               exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] x;
    logic [7:0] e;
    u_host.xfer(1'b0, a, d, x, e);
    chk(e, 8'h00);
    tick(2);
  endtask
  task automatic rd(input logic [14:0] a);
    logic [7:0] e;
    u_host.xfer(1'b1, a, 8'h00, rdv, e);
    chk(e, 8'hFF);
    tick(1);
  endtask
  task automatic pin(input logic v);
    @(posedge i_clk) i_shared_sync_powerdown_pin <= v;
    tick(3);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk(ana, 5'h00);
    chk(lane, 6'h0C);
    rd(pdc_pkg::ANALOG_PWR_OFS);
    chk(rdv, 8'h02);
    rd(pdc_pkg::OUTBUF_PWR_OFS);
    chk(rdv, 8'h0C);
    rd(pdc_pkg::PD_MASK_OFS);
    chk(rdv, 8'h00);
    rd(pdc_pkg::SYNC_REF_OFS);
    chk(rdv, 8'h00);
  endtask
  task automatic t_bits;
    wr(pdc_pkg::ANALOG_PWR_OFS, 8'h36);
    chk(ana, 5'h1C);
    wr(pdc_pkg::ANALOG_PWR_OFS, 8'h02);
    chk(ana, 5'h00);
    wr(pdc_pkg::OUTBUF_PWR_OFS, 8'h30);
    chk(lane, 6'h30);
    wr(pdc_pkg::OUTBUF_PWR_OFS, 8'h0F);
    chk(lane, 6'h0F);
    wr(pdc_pkg::OUTBUF_PWR_OFS, 8'h00);
    chk(lane, 6'h00);
    @(posedge i_clk) i_if_mode <= pdc_pkg::PDC_ONE_WIRE;
    tick(2);
    chk(lane, 6'h0A);
    @(posedge i_clk) i_if_mode <= pdc_pkg::PDC_HALF_WIRE;
    tick(2);
    chk(lane, 6'h0B);
    @(posedge i_clk) i_if_mode <= pdc_pkg::PDC_TWO_WIRE;
    tick(2);
    chk(lane, 6'h00);
  endtask
  task automatic t_global;
    wr(pdc_pkg::ANALOG_PWR_OFS, 8'h03);
    chk(ana, 5'h1D);
    chk(lane, 6'h3F);
    wr(pdc_pkg::PD_MASK_OFS, 8'h0E);
    chk(ana, 5'h07);
    wr(pdc_pkg::ANALOG_PWR_OFS, 8'h23);
    chk(ana, 5'h17);
    wr(pdc_pkg::ANALOG_PWR_OFS, 8'h02);
    chk(ana, 5'h00);
    chk(lane, 6'h00);
    wr(pdc_pkg::PD_MASK_OFS, 8'h00);
  endtask
  task automatic t_pin;
    pin(1'b1);
    chk(ana, 5'h1D);
    pin(1'b0);
    chk(ana, 5'h00);
    wr(pdc_pkg::SYNC_REF_OFS, 8'h80);
    s = n_sync;
    pin(1'b1);
    chk(16'(n_sync - s), 16'h0001);
    chk(ana, 5'h00);
    pin(1'b0);
  endtask
  task automatic t_soft;
    wr(pdc_pkg::SYNC_REF_OFS, 8'h20);
    s = n_sync;
    wr(pdc_pkg::SYNC_REF_OFS, 8'h60);
    chk(16'(n_sync - s), 16'h0001);
    wr(pdc_pkg::SYNC_REF_OFS, 8'h20);
    chk(16'(n_sync - s), 16'h0002);
    wr(pdc_pkg::SYNC_REF_OFS, 8'h40);
    chk(16'(n_sync - s), 16'h0002);
  endtask
  task automatic t_ref;
    wr(pdc_pkg::SYNC_REF_OFS, 8'h07);
    chk(refc, 4'h0);
    wr(pdc_pkg::SYNC_REF_OFS, 8'h0F);
    chk(refc, 4'hF);
    rd(pdc_pkg::SYNC_REF_OFS);
    chk(rdv, 8'h0F);
    wr(pdc_pkg::SYNC_REF_OFS, 8'h00);
    wr(15'h000A, 8'hFF);
    rd(15'h000A);
    chk(rdv, 8'h00);
    rd(pdc_pkg::ANALOG_PWR_OFS);
    chk(rdv, 8'h02);
  endtask
  // a reset in mid-run must bring back the analog and output buffer defaults, written or not
  task automatic t_rerun;
    wr(pdc_pkg::ANALOG_PWR_OFS, 8'h37);
    chk(ana, 5'h1D);
    chk(lane, 6'h3F);
    @(posedge i_clk) i_sys_rst <= 1'b1;
    tick(2);
    chk(ana, 5'h00);
    chk(lane, 6'h0C);
    @(posedge i_clk) i_sys_rst <= 1'b0;
    tick(1);
    rd(pdc_pkg::OUTBUF_PWR_OFS);
    chk(rdv, 8'h0C);
    rd(pdc_pkg::ANALOG_PWR_OFS);
    chk(rdv, 8'h02);
  endtask
  // ----------------------------------------
  // verdict and main sequence
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("errors %0d, comparisons %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge i_clk);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    tick(1);
    t_reset();
    t_bits();
    t_global();
    t_pin();
    t_soft();
    t_ref();
    t_rerun();
    tally_and_finish();
  end
endmodule // power_down_control_regs_bench
